// *** shared/ulp_pkg.sv ***
// Shared constants, encodings and carriers of the transceiver-side bus logic
// Assumes one 10 MHz clock and a synchronous, active-low reset everywhere
package ulp_pkg;

	// Bus width and fixed byte patterns
	localparam int          BYTE_W    = 8;
	localparam logic [7:0]  IDLE_BYTE = 8'h00;  // Link idles the bus low
	localparam logic [7:0]  OE_ALL    = 8'hFF;  // Every data line driven
	localparam logic [7:0]  OE_NONE   = 8'h00;  // Data lines released

	// Fixed data-line directions in the alternate modes
	localparam logic [7:0]  OE_LP     = 8'hFF;  // Low power: all outputs
	localparam logic [7:0]  OE_S6     = 8'hF8;  // 6-pin: bits 2..0 inputs
	localparam logic [7:0]  OE_S3     = 8'hF8;  // 3-pin: bits 1..2 swing
	localparam logic [7:0]  OE_S3_RX  = 8'h06;  // 3-pin receive extra lines

	// Field positions on the data lines
	localparam int          LP_LS0    = 0;      // Line state bit 0
	localparam int          LP_LS1    = 1;      // Line state bit 1
	localparam int          F_INT     = 3;      // Interrupt line
	localparam int          F_TXEN    = 0;      // Serial transmit enable
	localparam int          F_TXDAT   = 1;      // Serial transmit data
	localparam int          F_SE0     = 2;      // Serial single-ended zero
	localparam int          S6_DP     = 4;      // 6-pin receive DP
	localparam int          S6_DM     = 5;      // 6-pin receive DM
	localparam int          S6_RCV    = 6;      // 6-pin differential rx

	// Timing: interface clock and clock settle time
	localparam int          IFC_CLK_MHZ = 60;   // Interface clock rate
	localparam int          MCLK_NS     = 100;  // Our clock period
	localparam int          STABLE_NS   = 1000; // Clock settle wait
	localparam logic [7:0]  STABLE_CYC  =
		8'((STABLE_NS + MCLK_NS - 1) / MCLK_NS);

	// Top-level bus states
	typedef enum logic [2:0] {
		S_PWR, S_LISTEN, S_TURN_UP, S_DRIVE, S_TURN_DN, S_ALT
	} ulp_st_t;

	// Bus operating mode
	typedef enum logic [1:0] {M_SYNC, M_LP, M_S6, M_S3} ulp_mode_t;

	// Transmit receiver states
	typedef enum logic {T_IDLE, T_BUSY} ulp_tx_st_t;

	// Byte offered to the link with a request flag
	typedef struct packed {
		logic       req;
		logic [7:0] data;
	} ulp_byte_req_t;

	// Decoded USB receive stream
	typedef struct packed {
		logic       active;
		logic       valid;
		logic [7:0] data;
	} ulp_rx_t;

	// Mode requests from the register block
	typedef struct packed {
		logic lp;
		logic ser6;
		logic ser3;
	} ulp_mode_req_t;

	// Analog line levels shown in the alternate modes
	typedef struct packed {
		logic [1:0] linestate;
		logic       intr;
		logic       rx_dp;
		logic       rx_dm;
		logic       rx_rcv;
	} ulp_line_t;

	// Serial transmit levels taken from the link
	typedef struct packed {
		logic en;
		logic dat;
		logic se0;
	} ulp_sertx_t;

	// Bytes received from the link
	typedef struct packed {
		logic       cmd_stb;
		logic [7:0] cmd;
		logic       byte_stb;
		logic [7:0] data;
		logic       end_stb;
	} ulp_txo_t;

	// State of the transmit receiver
	typedef struct packed {
		ulp_tx_st_t st;
		logic       nxt_prev;
		ulp_txo_t   out;
	} ulp_txs_t;

	// State of the clock selector
	typedef struct packed {
		logic       cap;
		logic       strap;
		logic [7:0] cnt;
		logic       ready;
	} ulp_clks_t;

	// State of the top level
	typedef struct packed {
		ulp_st_t    st;
		ulp_mode_t  mode;
		logic       dir;
		logic       nxt;
		logic [7:0] dout;
		logic [7:0] oe;
		ulp_sertx_t sertx;
		logic       wake;
	} ulp_top_t;

	localparam ulp_txs_t  TXS_RST = '0;
	localparam ulp_clks_t CLK_RST = '0;
	localparam ulp_top_t  TOP_RST = '0;

endpackage : ulp_pkg

// *** hw/ulp_clk_sel.sv ***
// Interface clock direction and settle timer
// Assumes the crystal strap is static and valid once reset releases
`timescale 1ns/1ns
module ulp_clk_sel (
	input  wire logic mclk_i,            // System clock
	input  wire logic nrst_i,            // Synchronous reset, low
	input  wire logic crystal_in_pin_i,  // High when a crystal feeds us
	output logic      clk_oe_o,          // High: drive the interface clock
	output logic      ready_o            // Clock settled, bus usable
);
	import ulp_pkg::*;

	ulp_clks_t s_ff;   // Registered state
	ulp_clks_t nxt_s;  // Next state

	// Strap caught after release, then settle count runs
	always_comb begin
		nxt_s = s_ff;
		if (!s_ff.cap) begin
			// First cycle out of reset: catch the strap level
			nxt_s.cap   = 1'b1;
			nxt_s.strap = crystal_in_pin_i;
		end else if (!s_ff.ready) begin
			// Wait for the clock to settle before bus use
			if (s_ff.cnt >= STABLE_CYC - 8'h01) begin
				nxt_s.ready = 1'b1;
			end else begin
				nxt_s.cnt = s_ff.cnt + 8'h01;
			end
		end
	end

	// State register
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			s_ff <= CLK_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Crystal present: we source the clock, else the link does
	assign clk_oe_o = s_ff.cap & s_ff.strap;
	assign ready_o  = s_ff.ready;

endmodule : ulp_clk_sel

// *** hw/ulp_tx_rcv.sv ***
// Receiver for transmit commands and data sent by the link
// Assumes en_i is high only while direction is low and not turning around
`timescale 1ns/1ns
module ulp_tx_rcv (
	input  wire logic        mclk_i,   // System clock
	input  wire logic        nrst_i,   // Synchronous reset, low
	input  wire logic        en_i,     // Listening allowed
	input  wire logic        stp_i,    // Stop from the link
	input  wire logic [7:0]  data_i,   // Data lines as seen from the link
	input  wire logic        ready_i,  // Core can take a byte
	output logic             nxt_o,    // Throttle request to the link
	output logic             busy_o,   // Transmit in progress
	output ulp_pkg::ulp_txo_t txo_o    // Received command and bytes
);
	import ulp_pkg::*;

	ulp_txs_t s_ff;   // Registered state
	ulp_txs_t nxt_s;  // Next state
	logic     nxt_c;  // Throttle this cycle

	// Command detect, throttled byte capture, stop
	always_comb begin
		nxt_s              = s_ff;
		nxt_s.out.cmd_stb  = 1'b0;
		nxt_s.out.byte_stb = 1'b0;
		nxt_s.out.end_stb  = 1'b0;
		nxt_c              = 1'b0;
		case (s_ff.st)
			T_IDLE: begin
				// Nonzero byte opens a transfer
				if (en_i && data_i != IDLE_BYTE && ready_i) begin
					nxt_c             = 1'b1;
					nxt_s.out.cmd     = data_i;
					nxt_s.out.cmd_stb = 1'b1;
					nxt_s.st          = T_BUSY;
				end
			end
			T_BUSY: begin
				if (stp_i) begin
					// Stop ends the packet; this cycle holds no byte
					nxt_s.out.end_stb = 1'b1;
					nxt_s.st          = T_IDLE;
				end else begin
					// Byte asked for last cycle is on the bus now
					if (s_ff.nxt_prev) begin
						nxt_s.out.data     = data_i;
						nxt_s.out.byte_stb = 1'b1;
					end
					// Throttle only while the core can accept
					nxt_c = ready_i;
				end
			end
			default: nxt_s.st = T_IDLE;
		endcase
		nxt_s.nxt_prev = nxt_c;
	end

	// State register
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			s_ff <= TXS_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign nxt_o  = nxt_c;
	assign busy_o = (s_ff.st == T_BUSY);
	assign txo_o  = s_ff.out;

endmodule : ulp_tx_rcv

// *** hw/ulp_phy_bus.sv ***
// Transceiver side of the 8-bit low-pin-count bus handshake
// Operation
// - Throttle low unless actively throttling
// - Link gives next byte after throttle
// - Throttle high exactly with receive bytes
// - Throttle low for read data, status
// - Crystal present means we drive clock
// - Synchronous mode after power-up, clock stable
// - Direction change costs one turnaround cycle
// - Direction low by default, listening
// - Direction high only with bytes or in an alternate mode
// - Status byte unless read data returned
// - Stop during direction high aborts us
// - Abort drops direction next cycle
// - Stop held wakes back to synchronous
// - Other modes: no throttle, fixed lines
// Assumes all pins are synchronous to mclk_i and tri-state is resolved
// outside; the register block supplies mode requests and status bytes.
`timescale 1ns/1ns
module ulp_phy_bus (
	input  wire logic                  mclk_i,           // System clock
	input  wire logic                  nrst_i,           // Sync reset, low
	input  wire logic                  crystal_in_pin_i, // Crystal strap
	input  wire logic                  stp_i,            // Stop pin
	input  wire logic [7:0]            data_i,           // Data lines in
	output logic [7:0]                 data_o,           // Data lines out
	output logic [7:0]                 data_oe_o,        // Per-line enable
	output logic                       dir_o,            // Direction pin
	output logic                       nxt_o,            // Throttle pin
	output logic                       clk_oe_o,         // Drive clock pin
	output logic                       sync_ready_o,     // Bus usable
	input  wire ulp_pkg::ulp_rx_t      rx_i,             // USB receive
	output logic                       rx_take_o,        // Receive taken
	input  wire ulp_pkg::ulp_byte_req_t rxcmd_i,         // Status byte
	output logic                       rxcmd_take_o,     // Status sent
	input  wire ulp_pkg::ulp_byte_req_t regrd_i,         // Read data
	output logic                       regrd_take_o,     // Read data sent
	input  wire logic                  tx_ready_i,       // Core takes tx
	output ulp_pkg::ulp_txo_t          txo_o,            // Link tx bytes
	input  wire ulp_pkg::ulp_mode_req_t mode_req_i,      // Mode requests
	input  wire ulp_pkg::ulp_line_t    line_i,           // Line levels
	output ulp_pkg::ulp_sertx_t        sertx_o,          // Serial tx in
	output ulp_pkg::ulp_mode_t         mode_o,           // Current mode
	output logic                       wake_o            // Woke, pulse
);
	import ulp_pkg::*;

	ulp_top_t s_ff;      // Registered state
	ulp_top_t nxt_s;     // Next state
	logic     clk_ready; // Interface clock settled
	logic     tx_nxt;    // Throttle from transmit receiver
	logic     tx_busy;   // Link transmit in progress
	logic     tx_en;     // Transmit receiver may listen
	logic     want_out;  // Bytes waiting for the link
	logic     want_mode; // Alternate mode requested

	// Pick the single requested mode; link must request only one
	function automatic ulp_mode_t pick_mode(input ulp_mode_req_t r);
		ulp_mode_t m;
		m = M_SYNC;
		if (r.lp) begin
			m = M_LP;
		end else if (r.ser6) begin
			m = M_S6;
		end else if (r.ser3) begin
			m = M_S3;
		end
		return m;
	endfunction : pick_mode

	// Fixed line enables for a mode; 3-pin swings with transmit enable
	function automatic logic [7:0] mode_oe(input ulp_mode_t m,
		input logic txen);
		logic [7:0] oe;
		oe = OE_NONE;
		case (m)
			M_LP:    oe = OE_LP;
			M_S6:    oe = OE_S6;
			M_S3:    oe = txen ? OE_S3 : (OE_S3 | OE_S3_RX);
			default: oe = OE_NONE;
		endcase
		return oe;
	endfunction : mode_oe

	// Line values shown in each alternate mode; unused lines stay low
	function automatic logic [7:0] mode_dout(input ulp_mode_t m,
		input ulp_line_t l);
		logic [7:0] d;
		d = IDLE_BYTE;
		case (m)
			M_LP: begin
				d[LP_LS0] = l.linestate[0];
				d[LP_LS1] = l.linestate[1];
				d[F_INT]  = l.intr;
			end
			M_S6: begin
				d[F_INT]  = l.intr;
				d[S6_DP]  = l.rx_dp;
				d[S6_DM]  = l.rx_dm;
				d[S6_RCV] = l.rx_rcv;
			end
			M_S3: begin
				d[F_TXDAT] = l.rx_rcv;
				d[F_SE0]   = ~(l.rx_dp | l.rx_dm);
				d[F_INT]   = l.intr;
			end
			default: d = IDLE_BYTE;
		endcase
		return d;
	endfunction : mode_dout

	// Clock direction strap and settle timer
	ulp_clk_sel u_clk (
		.mclk_i           (mclk_i),
		.nrst_i           (nrst_i),
		.crystal_in_pin_i (crystal_in_pin_i),
		.clk_oe_o         (clk_oe_o),
		.ready_o          (clk_ready)
	);

	// Link-to-transceiver command and data receiver
	ulp_tx_rcv u_tx (
		.mclk_i  (mclk_i),
		.nrst_i  (nrst_i),
		.en_i    (tx_en),
		.stp_i   (stp_i),
		.data_i  (data_i),
		.ready_i (tx_ready_i),
		.nxt_o   (tx_nxt),
		.busy_o  (tx_busy),
		.txo_o   (txo_o)
	);

	// Reasons to turn the bus around toward the link
	assign want_out  = rx_i.active | rxcmd_i.req | regrd_i.req;
	assign want_mode = (pick_mode(mode_req_i) != M_SYNC);

	// Listen only with direction low, no turnaround, nothing to send unless a transmit is running;
	// when both sides want the bus in the same cycle we win it
	assign tx_en = (s_ff.st == S_LISTEN)
		& (tx_busy | ~(want_out | want_mode));

	// Bus direction, byte selection and mode sequencing
	always_comb begin
		nxt_s        = s_ff;
		nxt_s.nxt    = 1'b0;
		nxt_s.wake   = 1'b0;
		rx_take_o    = 1'b0;
		rxcmd_take_o = 1'b0;
		regrd_take_o = 1'b0;
		case (s_ff.st)
			S_PWR: begin
				// Hold the bus quiet until the clock has settled
				nxt_s.dir = 1'b0;
				nxt_s.oe  = OE_NONE;
				if (clk_ready) begin
					nxt_s.st   = S_LISTEN;
					nxt_s.mode = M_SYNC;
				end
			end
			S_LISTEN: begin
				// Default: direction low, data lines are inputs
				nxt_s.dir = 1'b0;
				nxt_s.oe  = OE_NONE;
				if (!tx_busy) begin
					if (want_mode) begin
						// Alternate mode: block the link first
						nxt_s.mode = pick_mode(mode_req_i);
						nxt_s.dir  = 1'b1;
						nxt_s.st   = S_TURN_UP;
					end else if (want_out) begin
						nxt_s.dir = 1'b1;
						nxt_s.st  = S_TURN_UP;
					end
				end
			end
			S_TURN_UP: begin
				// Turnaround: direction high, lines still released
				if (stp_i) begin
					// Abort before the first byte
					nxt_s.dir  = 1'b0;
					nxt_s.mode = M_SYNC;
					nxt_s.wake = (s_ff.mode != M_SYNC);
					nxt_s.st   = S_TURN_DN;
				end else if (s_ff.mode != M_SYNC) begin
					// Fixed directions from here on, no throttle
					nxt_s.oe   = mode_oe(s_ff.mode, data_i[F_TXEN]);
					nxt_s.dout = mode_dout(s_ff.mode, line_i);
					nxt_s.st   = S_ALT;
				end else begin
					nxt_s.oe = OE_ALL;
					nxt_s.st = S_DRIVE;
					// First byte: receive data, read data or status
					if (rx_i.valid) begin
						nxt_s.dout = rx_i.data;
						nxt_s.nxt  = 1'b1;
						rx_take_o  = 1'b1;
					end else if (regrd_i.req) begin
						nxt_s.dout   = regrd_i.data;
						regrd_take_o = 1'b1;
					end else begin
						nxt_s.dout   = rxcmd_i.data;
						rxcmd_take_o = rxcmd_i.req;
					end
				end
			end
			S_DRIVE: begin
				// Link stop while we hold the bus is an abort
				if (stp_i) begin
					nxt_s.dir = 1'b0;
					nxt_s.oe  = OE_NONE;
					nxt_s.st  = S_TURN_DN;
				end else if (rx_i.valid) begin
					// Decoded USB byte: the only case with throttle high
					nxt_s.dout = rx_i.data;
					nxt_s.nxt  = 1'b1;
					rx_take_o  = 1'b1;
				end else if (regrd_i.req) begin
					// Read data replaces the status byte
					nxt_s.dout   = regrd_i.data;
					regrd_take_o = 1'b1;
				end else if (rxcmd_i.req || rx_i.active) begin
					// Status byte fills every gap in a receive
					nxt_s.dout   = rxcmd_i.data;
					rxcmd_take_o = rxcmd_i.req;
				end else begin
					// Nothing left: release lines with direction
					nxt_s.dir  = 1'b0;
					nxt_s.oe   = OE_NONE;
					nxt_s.dout = IDLE_BYTE;
					nxt_s.st   = S_TURN_DN;
				end
			end
			S_TURN_DN: begin
				// Turnaround back; receiver stays deaf this cycle
				nxt_s.dir = 1'b0;
				nxt_s.oe  = OE_NONE;
				nxt_s.st  = S_LISTEN;
			end
			S_ALT: begin
				// Alternate modes: lines follow the analog front end
				nxt_s.oe   = mode_oe(s_ff.mode, data_i[F_TXEN]);
				nxt_s.dout = mode_dout(s_ff.mode, line_i);
				if (s_ff.mode != M_LP) begin
					// Serial transmit levels come in on the low lines
					nxt_s.sertx.en  = data_i[F_TXEN];
					nxt_s.sertx.dat = data_i[F_TXDAT];
					nxt_s.sertx.se0 = data_i[F_SE0];
				end
				if (stp_i) begin
					// Stop held high wakes us back to synchronous mode
					nxt_s.mode  = M_SYNC;
					nxt_s.dir   = 1'b0;
					nxt_s.oe    = OE_NONE;
					nxt_s.dout  = IDLE_BYTE;
					nxt_s.sertx = '0;
					nxt_s.wake  = 1'b1;
					nxt_s.st    = S_TURN_DN;
				end
			end
			default: begin
				// Unreachable encodings fall back to a clean start
				nxt_s = TOP_RST;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk_i) begin
		if (!nrst_i) begin
			s_ff <= TOP_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// Pin outputs; throttle is only ever raised in synchronous mode
	assign dir_o        = s_ff.dir;
	assign nxt_o        = s_ff.nxt | tx_nxt;
	assign data_o       = s_ff.dout;
	assign data_oe_o    = s_ff.oe;
	assign sync_ready_o = clk_ready;
	assign sertx_o      = s_ff.sertx;
	assign mode_o       = s_ff.mode;
	assign wake_o       = s_ff.wake;

endmodule : ulp_phy_bus

// *** testbench/ulp_phy_bus_monitor.sv ***
// Port-level checker for the transceiver bus handshake
// Assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module ulp_phy_bus_monitor (
	input wire logic			mclk_i,
	input wire logic			nrst_i,
	input wire logic			crystal_in_pin_i,
	input wire logic			stp_i,
	input wire logic [7:0]			data_oe_o,
	input wire logic			dir_o,
	input wire logic			nxt_o,
	input wire logic			clk_oe_o,
	input wire logic			sync_ready_o,
	input wire ulp_pkg::ulp_rx_t		rx_i,
	input wire ulp_pkg::ulp_byte_req_t	rxcmd_i,
	input wire ulp_pkg::ulp_byte_req_t	regrd_i,
	input wire logic			tx_ready_i,
	input wire ulp_pkg::ulp_mode_req_t	mode_req_i,
	input wire ulp_pkg::ulp_mode_t		mode_o,
	input wire logic			wake_o
);
	import ulp_pkg::*;
	// One domain, so clock and reset are stated once
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!nrst_i);
	// Listening: throttle only while the core can take a byte
	property p_nxt_tx;
		!dir_o && !tx_ready_i |-> !nxt_o;
	endproperty
	a_nxt_tx: assert property (p_nxt_tx)
		else $error("throttle without ready core");
	// Returning: throttle marks only driven receive bytes
	property p_nxt_rx;
		dir_o && nxt_o |-> data_oe_o == OE_ALL && mode_o == M_SYNC;
	endproperty
	a_nxt_rx: assert property (p_nxt_rx)
		else $error("throttle on a non-data cycle");
	// Every direction change leaves the lines undriven
	property p_turn;
		$changed(dir_o) |-> data_oe_o == OE_NONE && !nxt_o;
	endproperty
	a_turn: assert property (p_turn)
		else $error("lines driven in turnaround");
	// Lines only driven once direction has been high a cycle
	property p_oe_dir;
		data_oe_o != OE_NONE |-> dir_o && $past(dir_o);
	endproperty
	a_oe_dir: assert property (p_oe_dir)
		else $error("lines driven without owning bus");
	// Stop while we own the bus gives it back next cycle
	property p_abort;
		dir_o && stp_i |=> !dir_o;
	endproperty
	a_abort: assert property (p_abort)
		else $error("direction kept after stop");
	property p_wake;
		mode_o != M_SYNC && stp_i |=> wake_o && mode_o == M_SYNC;
	endproperty
	a_wake: assert property (p_wake)
		else $error("stop did not wake to sync mode");
	property p_alt_nxt;
		mode_o != M_SYNC |-> !nxt_o;
	endproperty
	a_alt_nxt: assert property (p_alt_nxt)
		else $error("throttle used outside sync mode");
	// Direction rises only with something to return
	property p_dir_cause;
		!dir_o && !(rx_i.active || rxcmd_i.req || regrd_i.req ||
			mode_req_i != 3'h0) |=> !dir_o;
	endproperty
	a_dir_cause: assert property (p_dir_cause)
		else $error("direction raised with nothing to send");
	property p_clk;
		sync_ready_o |-> clk_oe_o == crystal_in_pin_i;
	endproperty
	a_clk: assert property (p_clk)
		else $error("clock direction does not follow strap");
	c_rx: cover property (dir_o && nxt_o);
	c_abort: cover property (dir_o && stp_i);
	c_wake: cover property (wake_o);
endmodule : ulp_phy_bus_monitor

// *** testbench/ulp_link_model.sv ***
// Behavioural link controller on the far side of the bus
// Assumes its tasks are called just after a rising clock edge
`timescale 1ns/1ns
module ulp_link_model (
	input  wire logic	mclk_i,	// Bus clock
	input  wire logic	dir_i,	// Direction from transceiver
	input  wire logic	nxt_i,	// Throttle from transceiver
	output logic [7:0]	data_o,	// Lines as we drive them
	output logic		stp_o	// Stop line
);
	logic [7:0]	d_ff = 8'h00;	// Byte presented while listening
	// Released lines fall to the weak pull-downs, never the last byte
	assign data_o = dir_i ? 8'h00 : d_ff;
	initial stp_o = 1'b0;
	// Command then payload; step only when throttle was seen
	task automatic send(input logic [7:0] p[$]);
		int i;
		int k;
		i = 0;
		d_ff <= p[0];
		for (k = 0; k < 300 && i < p.size(); k++) begin
			@(posedge mclk_i);
			if (nxt_i) begin
				i++;
				d_ff <= (i < p.size()) ? p[i] : 8'h00;
				stp_o <= (i == p.size());
			end
		end
		@(posedge mclk_i);
		stp_o <= 1'b0;
	endtask : send
	// Stop level for abort or wake-up
	task automatic stp_set(input logic v);
		@(posedge mclk_i);
		stp_o <= v;
	endtask : stp_set
endmodule : ulp_link_model

// *** testbench/ulp_phy_bus_tb.sv ***
// Self-checking bench for the transceiver bus handshake
// Assumes the link model beside the design and the monitor bound below
`timescale 1ns/1ns
module ulp_phy_bus_tb;
	import ulp_pkg::*;
	logic		mclk_i = 1'b0;
	logic		nrst_i = 1'b0;
	logic		crystal_in_pin_i = 1'b0;
	logic		tx_ready_i = 1'b0;
	ulp_rx_t	rx_i = '0;
	ulp_byte_req_t	rxcmd_i = '0;
	ulp_byte_req_t	regrd_i = '0;
	ulp_mode_req_t	mode_req_i = '0;
	ulp_line_t	line_i = '0;
	logic [7:0]	data_o, data_oe_o, ldat, bus, rxd;
	logic		dir_o, nxt_o, clk_oe_o, sync_ready_o, stp_i;
	logic		rx_take_o, rxcmd_take_o, regrd_take_o, wake_o;
	ulp_txo_t	txo_o;
	ulp_sertx_t	sertx_o;
	ulp_mode_t	mode_o;
	int		failures = 0;
	int		num_checks = 0;
	int		seed = 48;
	int		rx_n = 0;	// Receive bytes still to offer
	int		k;
	int		m;
	logic [9:0]	exp_tx[$];	// Expected link-side strobes
	logic [9:0]	exp_rx[$];	// Expected {nxt, byte} we return
	logic [7:0]	oe_tab[3] = '{OE_LP, OE_S6, OE_S6 | OE_S3_RX};
	ulp_mode_t	md_tab[3] = '{M_LP, M_S6, M_S3};
	logic [7:0]	rsv_tab[3] = '{8'hF4, 8'h80, 8'hF0};	// Reserved lines

	always #50 mclk_i = ~mclk_i;
	// Each line follows whoever enables it
	assign bus = (data_o & data_oe_o) | (ldat & ~data_oe_o);

	ulp_phy_bus dut_u (
		.mclk_i(mclk_i), .nrst_i(nrst_i),
		.crystal_in_pin_i(crystal_in_pin_i), .stp_i(stp_i),
		.data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
		.dir_o(dir_o), .nxt_o(nxt_o), .clk_oe_o(clk_oe_o),
		.sync_ready_o(sync_ready_o), .rx_i(rx_i), .rx_take_o(rx_take_o),
		.rxcmd_i(rxcmd_i), .rxcmd_take_o(rxcmd_take_o),
		.regrd_i(regrd_i), .regrd_take_o(regrd_take_o),
		.tx_ready_i(tx_ready_i), .txo_o(txo_o), .mode_req_i(mode_req_i),
		.line_i(line_i), .sertx_o(sertx_o), .mode_o(mode_o),
		.wake_o(wake_o)
	);
	ulp_link_model link_u (
		.mclk_i(mclk_i), .dir_i(dir_o), .nxt_i(nxt_o), .data_o(ldat),
		.stp_o(stp_i)
	);

	task automatic end_of_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test
	task automatic tmo();
		failures++;
		$display("CHECK FAILED t=%0t wait ran out", $time);
		end_of_test();
	endtask : tmo
	task automatic check(input logic [9:0] got, input logic [9:0] exp,
		input string msg);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t %s %h/%h", $time, msg, got, exp);
		end
	endtask : check
	// Oldest note must exist and match
	task automatic pop(ref logic [9:0] q[$], input logic [9:0] got);
		check({9'h0, q.size() != 0}, 10'h1, "spare result");
		if (q.size() != 0)
			check(got, q.pop_front(), "result");
	endtask : pop
	task automatic wait_oe(input logic [7:0] v);
		for (k = 0; k < 60 && data_oe_o !== v; k++)
			@(negedge mclk_i);
		if (k == 60)
			tmo();
	endtask : wait_oe
	task automatic wait_dir_lo();
		for (k = 0; k < 200 && dir_o !== 1'b0; k++)
			@(negedge mclk_i);
		if (k == 200)
			tmo();
	endtask : wait_dir_lo
	// Reset 8 cycles, then wait for the settled clock plus 2 cycles
	task automatic do_reset(input logic strap);
		nrst_i <= 1'b0;
		crystal_in_pin_i <= strap;
		repeat (8) @(posedge mclk_i);
		nrst_i <= 1'b1;
		for (k = 0; k < 40 && sync_ready_o !== 1'b1; k++)
			@(posedge mclk_i);
		if (k == 40)
			tmo();
		repeat (2) @(posedge mclk_i);
		@(negedge mclk_i);
	endtask : do_reset
	// Note the strobes first, then let the link send
	task automatic send_tx(input int n);
		logic [7:0] p[$];
		int i;
		p.push_back(8'h40 | (8'($random(seed)) & 8'h3F));
		exp_tx.push_back({2'd1, p[0]});
		for (i = 0; i < n; i++) begin
			p.push_back(8'($random(seed)));
			exp_tx.push_back({2'd2, p[i + 1]});
		end
		exp_tx.push_back({2'd3, 8'h00});
		@(posedge mclk_i);
		link_u.send(p);
	endtask : send_tx

	// Random readiness keeps throttling awkward
	always @(posedge mclk_i) begin
		tx_ready_i <= ($random(seed) & 3) != 0;
		line_i <= 6'($random(seed));
	end
	// Offer receive bytes in order, each held until taken
	always @(posedge mclk_i) begin
		if (rxcmd_take_o === 1'b1)
			rxcmd_i.req <= 1'b0;
		if (regrd_take_o === 1'b1)
			regrd_i.req <= 1'b0;
		if (rx_take_o === 1'b1 || !rx_i.valid) begin
			if (rx_n > 0) begin
				rxd = 8'($random(seed));
				exp_rx.push_back({2'b01, rxd});
				rx_i <= {1'b1, 1'b1, rxd};
				rx_n--;
			end else
				rx_i <= '0;
		end
	end
	// Compare each result as it appears
	always @(negedge mclk_i) begin
		if (txo_o.cmd_stb === 1'b1)
			pop(exp_tx, {2'd1, txo_o.cmd});
		if (txo_o.byte_stb === 1'b1)
			pop(exp_tx, {2'd2, txo_o.data});
		if (txo_o.end_stb === 1'b1)
			pop(exp_tx, {2'd3, 8'h00});
		if (dir_o === 1'b1 && data_oe_o === OE_ALL && mode_o === M_SYNC)
			pop(exp_rx, {1'b0, nxt_o, data_o});
	end

	initial begin
		@(posedge mclk_i);
		do_reset(1'b0);
		check({9'h0, clk_oe_o}, 10'h0, "clock in");
		do_reset(1'b1);
		check({9'h0, clk_oe_o}, 10'h1, "clock out");
		check({7'h0, dir_o, mode_o}, {8'h0, M_SYNC}, "boot");
		send_tx(0);
		for (m = 1; m < 6; m++)
			send_tx(m);
		// Read data outranks the status byte
		@(posedge mclk_i);
		exp_rx.push_back({2'b00, 8'hA5});
		exp_rx.push_back({2'b00, 8'h3C});
		regrd_i <= {1'b1, 8'hA5};
		rxcmd_i <= {1'b1, 8'h3C};
		wait_oe(OE_ALL);
		wait_dir_lo();
		rx_n = 6;
		wait_oe(OE_ALL);
		wait_dir_lo();
		// Abort a long receive in mid-stream
		rx_n = 40;
		wait_oe(OE_ALL);
		link_u.stp_set(1'b1);
		@(negedge mclk_i);
		rx_n = 0;
		rx_i <= '0;
		link_u.stp_set(1'b0);
		@(negedge mclk_i);
		check({9'h0, dir_o}, 10'h0, "abort");
		exp_rx.delete();
		// One mode at a time, each left by holding stop
		for (m = 0; m < 3; m++) begin
			@(posedge mclk_i);
			mode_req_i <= 3'b100 >> m;
			wait_oe(oe_tab[m]);
			mode_req_i <= '0;
			check({8'h0, mode_o}, {8'h0, md_tab[m]}, "mode");
			check({2'h0, data_o & rsv_tab[m]}, 10'h0, "reserved");
			check({7'h0, sertx_o}, 10'h0, "serial tx");
			link_u.stp_set(1'b1);
			for (k = 0; k < 20 && wake_o !== 1'b1; k++)
				@(negedge mclk_i);
			check({8'h0, mode_o}, {8'h0, M_SYNC}, "wake");
			link_u.stp_set(1'b0);
			wait_dir_lo();
		end
		for (k = 0; k < 20 && exp_tx.size() + exp_rx.size() != 0; k++)
			@(negedge mclk_i);
		check(10'(exp_tx.size() + exp_rx.size()), 10'h0, "left");
		end_of_test();
	end
endmodule : ulp_phy_bus_tb

bind ulp_phy_bus ulp_phy_bus_monitor mon_u (
	.mclk_i(mclk_i), .nrst_i(nrst_i),
	.crystal_in_pin_i(crystal_in_pin_i), .stp_i(stp_i),
	.data_oe_o(data_oe_o), .dir_o(dir_o), .nxt_o(nxt_o),
	.clk_oe_o(clk_oe_o), .sync_ready_o(sync_ready_o), .rx_i(rx_i),
	.rxcmd_i(rxcmd_i), .regrd_i(regrd_i), .tx_ready_i(tx_ready_i),
	.mode_req_i(mode_req_i), .mode_o(mode_o), .wake_o(wake_o)
);
